// [mlsg_regs.sv]
// Purpose: Motor limit and supply guard register bank behind command codes
// Assumes: A framing UART core hands over whole commands on clk
// Notes:   Every command is answered one cycle after it is taken
`timescale 1ns/1ns
`default_nettype none
module mlsg_regs
	import mlsg_pkg::*;
#(
	parameter logic [VAL_W-1:0] OV_INTERNAL_MAX = OV_LIMIT_DFLT
)
(
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic                        cmd_valid,
	input  wire logic [BYTE_W-1:0]           cmd_code,
	input  wire logic [BYTE_W-1:0]           cmd_byte_hi,
	input  wire logic [BYTE_W-1:0]           cmd_byte_lo,
	input  wire logic [VAL_W-1:0]            regen_pot,
	input  wire logic [VAL_W-1:0]            ramp_pot,
	input  wire logic [NSLOT-1:0]            lock_mask,
	input  wire logic [NSLOT-1:0]            nv_saved_mask,
	input  wire logic [NSLOT-1:0][VAL_W-1:0] nv_value,
	input  wire logic [VAL_W-1:0]            supply_level,
	input  wire logic [VAL_W-1:0]            heatsink_raw,
	input  wire logic [HALF_W-1:0]           board_raw,
	output logic                             rsp_valid,
	output logic                             rsp_error,
	output logic      [BYTE_W-1:0]           rsp_byte_hi,
	output logic      [BYTE_W-1:0]           rsp_byte_lo,
	output logic      [VAL_W-1:0]            regen_cap,
	output logic      [VAL_W-1:0]            rise_ramp,
	output logic      [VAL_W-1:0]            fall_ramp,
	output logic                             fall_ramp_en,
	output logic                             output_shutdown,
	output logic                             low_supply_status,
	output logic                             high_supply_status
);

	// Strips the write bit and maps a code onto a storage slot
	function automatic logic [SLOT_W:0] decode_slot(
		input logic [BYTE_W-1:0] code
	);
		logic [BYTE_W-1:0] base;
		base = code & ~CMD_WRITE_BIT;
		if (base >= OFS_REGEN && base <= OFS_OV_SHUT) begin
			decode_slot = {1'b1, SLOT_W'(base - OFS_REGEN)};
		end else begin
			decode_slot = {1'b0, SLOT_W'(0)};
		end
	endfunction

	// Two data bytes, each with its top bit clear
	function automatic logic [2*BYTE_W-1:0] pack_bytes(
		input logic [VAL_W-1:0] val
	);
		logic [WIRE_W-1:0] wide;
		wide = WIRE_W'(val);
		pack_bytes = {1'b0, wide[WIRE_W-1:HALF_W], 1'b0, wide[HALF_W-1:0]};
	endfunction

	logic [SLOT_W:0]          wr_dec;
	logic [SLOT_W:0]          rd_dec;
	logic                     is_write;
	logic                     wr_hit;
	logic [SLOT_W-1:0]        wr_slot;
	logic [WIRE_W-1:0]        wr_wire;
	logic [VAL_W-1:0]         wr_value;
	logic [VAL_W-1:0]         ov_clamped;
	logic [NSLOT-1:0]         active;
	logic [VAL_W-1:0]         slot_val [NSLOT];
	logic [VAL_W-1:0]         rd_value;
	logic                     rd_known;

	logic                     restore_ff;
	logic [VAL_W-1:0]         plain_ff [SLOT_FALL:SLOT_OV_SHUT];
	logic [NSLOT-1:0]         written_ff;
	logic                     low_ff;
	logic                     high_ff;
	logic                     shutdown_ff;
	logic [VAL_W-1:0]         heat_ff;
	logic [HALF_W-1:0]        board_ff;
	logic                     rsp_valid_ff;
	logic                     rsp_error_ff;
	logic [BYTE_W-1:0]        rsp_hi_ff;
	logic [BYTE_W-1:0]        rsp_lo_ff;

	assign is_write = (cmd_code & CMD_WRITE_BIT) != 8'h00;
	assign wr_dec   = decode_slot(cmd_code);
	assign rd_dec   = decode_slot(cmd_code);
	assign wr_hit   = cmd_valid && is_write && wr_dec[SLOT_W];
	assign wr_slot  = wr_dec[SLOT_W-1:0];
	// Top bit of each data byte is ignored
	assign wr_wire  = {cmd_byte_hi[HALF_W-1:0], cmd_byte_lo[HALF_W-1:0]};
	// Bits 13..12 do not exist in storage
	assign wr_value = wr_wire[VAL_W-1:0];
	assign ov_clamped = (wr_value > OV_INTERNAL_MAX) ?
		OV_INTERNAL_MAX : wr_value;

	// Restore of saved values runs once, the cycle after reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			restore_ff <= 1'b1;
		end else begin
			restore_ff <= 1'b0;
		end
	end

	mlsg_mirror_reg u_regen (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.wr_en         (wr_hit && wr_slot == SLOT_REGEN),
		.wr_value      (wr_value),
		.restore_en    (restore_ff && nv_saved_mask[SLOT_REGEN]),
		.restore_value (nv_value[SLOT_REGEN]),
		.pot_value     (regen_pot),
		.lock          (lock_mask[SLOT_REGEN]),
		.value         (slot_val[SLOT_REGEN])
	);

	mlsg_mirror_reg u_rise (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.wr_en         (wr_hit && wr_slot == SLOT_RISE),
		.wr_value      (wr_value),
		.restore_en    (restore_ff && nv_saved_mask[SLOT_RISE]),
		.restore_value (nv_value[SLOT_RISE]),
		.pot_value     (ramp_pot),
		.lock          (lock_mask[SLOT_RISE]),
		.value         (slot_val[SLOT_RISE])
	);

	// Unmirrored slots: fall ramp and the four supply thresholds
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = SLOT_FALL; i <= SLOT_OV_SHUT; i++) begin
				plain_ff[i] <= VAL_RESET;
			end
		end else begin
			// Per slot, so a write in the restore cycle spares the others
			for (int i = SLOT_FALL; i <= SLOT_OV_SHUT; i++) begin
				if (wr_hit && wr_slot == SLOT_W'(i)) begin
					plain_ff[i] <= (i == SLOT_OV_SHUT) ?
						ov_clamped : wr_value;
				end else if (restore_ff && nv_saved_mask[i]) begin
					plain_ff[i] <= nv_value[i];
				end
			end
		end
	end

	// Written marks enable fall ramp and thresholds; saved counts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			written_ff <= '0;
		end else begin
			for (int i = 0; i < NSLOT; i++) begin
				if ((wr_hit && wr_slot == SLOT_W'(i)) ||
					(restore_ff && nv_saved_mask[i])) begin
					written_ff[i] <= 1'b1;
				end
			end
		end
	end

	generate
		for (genvar g = SLOT_FALL; g <= SLOT_OV_SHUT; g++) begin : g_slot
			assign slot_val[g] = plain_ff[g];
		end
		for (genvar g = 0; g < NSLOT; g++) begin : g_act
			assign active[g] = written_ff[g] && lock_mask[g];
		end
	endgenerate

	// Without its recover level a state ends when the trip level clears
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_ff <= 1'b0;
		end else if (active[SLOT_UV_SHUT] &&
			supply_level < slot_val[SLOT_UV_SHUT]) begin
			low_ff <= 1'b1;
		end else if (active[SLOT_UV_RECOVER]) begin
			if (supply_level > slot_val[SLOT_UV_RECOVER]) begin
				low_ff <= 1'b0;
			end
		end else begin
			low_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			high_ff <= 1'b0;
		end else if (active[SLOT_OV_SHUT] &&
			supply_level > slot_val[SLOT_OV_SHUT]) begin
			high_ff <= 1'b1;
		end else if (active[SLOT_OV_RECOVER]) begin
			if (supply_level < slot_val[SLOT_OV_RECOVER]) begin
				high_ff <= 1'b0;
			end
		end else begin
			high_ff <= 1'b0;
		end
	end

	// Shutdown trips in the same cycle as the status bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shutdown_ff <= 1'b0;
		end else begin
			shutdown_ff <= (active[SLOT_UV_SHUT] &&
				supply_level < slot_val[SLOT_UV_SHUT]) ||
				(active[SLOT_OV_SHUT] &&
				supply_level > slot_val[SLOT_OV_SHUT]) ||
				(low_ff && !(active[SLOT_UV_RECOVER] ?
				supply_level > slot_val[SLOT_UV_RECOVER] :
				!active[SLOT_UV_SHUT] ||
				supply_level >= slot_val[SLOT_UV_SHUT])) ||
				(high_ff && !(active[SLOT_OV_RECOVER] ?
				supply_level < slot_val[SLOT_OV_RECOVER] :
				!active[SLOT_OV_SHUT] ||
				supply_level <= slot_val[SLOT_OV_SHUT]));
		end
	end

	// Sensor values sampled every cycle; heatsink kept inside its range
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			heat_ff  <= TEMP_MIN;
			board_ff <= '0;
		end else begin
			if (heatsink_raw < TEMP_MIN) begin
				heat_ff <= TEMP_MIN;
			end else if (heatsink_raw > TEMP_MAX) begin
				heat_ff <= TEMP_MAX;
			end else begin
				heat_ff <= heatsink_raw;
			end
			board_ff <= board_raw;
		end
	end

	always_comb begin
		rd_known = 1'b1;
		rd_value = VAL_RESET;
		if (rd_dec[SLOT_W]) begin
			rd_value = slot_val[rd_dec[SLOT_W-1:0]];
		end else if (!is_write && cmd_code == OFS_HEATSINK) begin
			rd_value = heat_ff;
		end else if (!is_write && cmd_code == OFS_BOARD) begin
			rd_value = VAL_W'(board_ff);
		end else begin
			rd_known = 1'b0;
		end
	end

	// Writes echo the value as it will be stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_error_ff <= 1'b0;
			rsp_hi_ff    <= '0;
			rsp_lo_ff    <= '0;
		end else begin
			rsp_valid_ff <= cmd_valid;
			rsp_error_ff <= cmd_valid && !rd_known;
			if (cmd_valid && wr_hit) begin
				{rsp_hi_ff, rsp_lo_ff} <= pack_bytes(
					(wr_slot == SLOT_OV_SHUT) ? ov_clamped : wr_value);
			end else if (cmd_valid && rd_known) begin
				{rsp_hi_ff, rsp_lo_ff} <= pack_bytes(rd_value);
			end else begin
				{rsp_hi_ff, rsp_lo_ff} <= '0;
			end
		end
	end

	// Fall ramp is not guarded against zero; the host keeps it at 1 or more
	assign fall_ramp_en       = written_ff[SLOT_FALL];
	assign regen_cap          = slot_val[SLOT_REGEN];
	assign rise_ramp          = slot_val[SLOT_RISE];
	assign fall_ramp          = plain_ff[SLOT_FALL];
	assign output_shutdown    = shutdown_ff;
	assign low_supply_status  = low_ff;
	assign high_supply_status = high_ff;
	assign rsp_valid          = rsp_valid_ff;
	assign rsp_error          = rsp_error_ff;
	assign rsp_byte_hi        = rsp_hi_ff;
	assign rsp_byte_lo        = rsp_lo_ff;

endmodule
`default_nettype wire

// [mlsg_pkg.sv]
// Purpose: Shared constants for the motor limit and supply guard registers
// Assumes: 12-bit values carried as 14 bits in two 7-bit data bytes
// Notes:   Slot numbers are register offsets minus the first offset
package mlsg_pkg;

	localparam int VAL_W   = 12;
	localparam int WIRE_W  = 14;
	localparam int BYTE_W  = 8;
	localparam int HALF_W  = 7;
	localparam int SLOT_W  = 3;
	localparam int NSLOT   = 7;

	// Read command codes equal the register offsets
	localparam logic [7:0] OFS_REGEN      = 8'h03;
	localparam logic [7:0] OFS_RISE       = 8'h04;
	localparam logic [7:0] OFS_FALL       = 8'h05;
	localparam logic [7:0] OFS_UV_SHUT    = 8'h06;
	localparam logic [7:0] OFS_UV_RECOVER = 8'h07;
	localparam logic [7:0] OFS_OV_RECOVER = 8'h08;
	localparam logic [7:0] OFS_OV_SHUT    = 8'h09;
	localparam logic [7:0] OFS_HEATSINK   = 8'h0a;
	localparam logic [7:0] OFS_BOARD      = 8'h0b;

	// Write code is read code plus this bit
	localparam logic [7:0] CMD_WRITE_BIT  = 8'h40;

	localparam logic [SLOT_W-1:0] SLOT_REGEN      = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_RISE       = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_FALL       = 3'h2;
	localparam logic [SLOT_W-1:0] SLOT_UV_SHUT    = 3'h3;
	localparam logic [SLOT_W-1:0] SLOT_UV_RECOVER = 3'h4;
	localparam logic [SLOT_W-1:0] SLOT_OV_RECOVER = 3'h5;
	localparam logic [SLOT_W-1:0] SLOT_OV_SHUT    = 3'h6;

	localparam logic [VAL_W-1:0] VAL_RESET     = 12'h000;
	localparam logic [VAL_W-1:0] TEMP_MIN      = 12'h00a;
	localparam logic [VAL_W-1:0] TEMP_MAX      = 12'h050;
	localparam logic [VAL_W-1:0] OV_LIMIT_DFLT = 12'h997;

endpackage

// [mlsg_mirror_reg.sv]
// Purpose: One register that follows potentiometer changes while unlocked
// Assumes: Pot reading arrives on the same clock, already filtered
// Notes:   A write wins over a pot change in the same cycle
`timescale 1ns/1ns
`default_nettype none
module mlsg_mirror_reg
	import mlsg_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             wr_en,
	input  wire logic [VAL_W-1:0] wr_value,
	input  wire logic             restore_en,
	input  wire logic [VAL_W-1:0] restore_value,
	input  wire logic [VAL_W-1:0] pot_value,
	input  wire logic             lock,
	output logic      [VAL_W-1:0] value
);

	logic [VAL_W-1:0] value_ff;
	logic [VAL_W-1:0] pot_prev_ff;
	logic             pot_moved;

	// Prev starts at reset value so a nonzero pot is taken at once
	assign pot_moved = (pot_value != pot_prev_ff);
	assign value     = value_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pot_prev_ff <= VAL_RESET;
		end else begin
			pot_prev_ff <= pot_value;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			value_ff <= VAL_RESET;
		end else if (wr_en) begin
			value_ff <= wr_value;
		end else if (restore_en) begin
			value_ff <= restore_value;
		end else if (pot_moved && !lock) begin
			value_ff <= pot_value;
		end
	end

endmodule
`default_nettype wire

// [mlsg_regs_properties.sv]
// Purpose: Port timing checks for the guard register bank
// Assumes: Bound to mlsg_regs, one clock, sync reset
// Notes:   Sees only top-level ports
`timescale 1ns/1ns
`default_nettype none
module mlsg_regs_properties
	import mlsg_pkg::*;
#(
	parameter logic [VAL_W-1:0] OV_INTERNAL_MAX = OV_LIMIT_DFLT
)
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              cmd_valid,
	input wire logic [BYTE_W-1:0] cmd_code,
	input wire logic [BYTE_W-1:0] cmd_byte_hi,
	input wire logic [BYTE_W-1:0] cmd_byte_lo,
	input wire logic [NSLOT-1:0]  lock_mask,
	input wire logic              rsp_valid,
	input wire logic              rsp_error,
	input wire logic [BYTE_W-1:0] rsp_byte_hi,
	input wire logic [BYTE_W-1:0] rsp_byte_lo,
	input wire logic [VAL_W-1:0]  regen_cap,
	input wire logic              fall_ramp_en,
	input wire logic              output_shutdown,
	input wire logic              low_supply_status,
	input wire logic              high_supply_status
);
	logic regen_wr;
	assign regen_wr = cmd_valid && cmd_code == 8'h43;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_answer_next: assert property (
		cmd_valid |=> rsp_valid)
		else $error("Command not answered next cycle");
	a_byte_form: assert property (
		rsp_valid |-> rsp_byte_hi[7:5] == 3'h0 && !rsp_byte_lo[7])
		else $error("Answer byte has a stray top bit");
	a_ro_refuse: assert property (
		cmd_valid && (cmd_code == 8'h4a || cmd_code == 8'h4b) |=>
		rsp_error && rsp_byte_hi == 8'h00 && rsp_byte_lo == 8'h00)
		else $error("Write to temperature not refused");
	a_regen_write: assert property (
		regen_wr |=> regen_cap == $past({cmd_byte_hi[4:0], cmd_byte_lo[6:0]}))
		else $error("Regen cap not loaded from write");
	a_fall_enable: assert property (
		cmd_valid && cmd_code == 8'h45 |=> fall_ramp_en)
		else $error("Fall ramp not enabled by write");
	// Restore cycle excluded: saved values may load there
	a_lock_hold: assert property (
		lock_mask[0] && !regen_wr && !$past(sys_rst) |=> $stable(regen_cap))
		else $error("Locked regen cap changed");
	a_shut_cause: assert property (
		low_supply_status || high_supply_status |-> output_shutdown)
		else $error("Supply fault without shutdown");
	a_low_locked: assert property (
		$rose(low_supply_status) |-> $past(lock_mask[3]))
		else $error("Low supply set by unlocked level");
	a_ov_clamp: assert property (
		cmd_valid && cmd_code == 8'h49 |=>
		{rsp_byte_hi[4:0], rsp_byte_lo[6:0]} <= OV_INTERNAL_MAX)
		else $error("Overvolt level above internal max");
	c_low: cover property ($rose(low_supply_status));
	c_high: cover property ($rose(high_supply_status));
	c_refused: cover property (rsp_error);
endmodule
bind mlsg_regs mlsg_regs_properties #(
	.OV_INTERNAL_MAX(OV_INTERNAL_MAX)
) u_props (.clk, .sys_rst, .cmd_valid, .cmd_code, .cmd_byte_hi,
	.cmd_byte_lo, .lock_mask, .rsp_valid, .rsp_error, .rsp_byte_hi,
	.rsp_byte_lo, .regen_cap, .fall_ramp_en, .output_shutdown,
	.low_supply_status, .high_supply_status);
`default_nettype wire

// [mlsg_host_model.sv]
// Purpose: Serial host that sends whole commands to the bank
// Assumes: Answer stands from the taking edge to the next one
// Notes:   Released lines carry inverted junk
`timescale 1ns/1ns
`default_nettype none
module mlsg_host_model
	import mlsg_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rsp_valid,
	input  wire logic              rsp_error,
	input  wire logic [BYTE_W-1:0] rsp_byte_hi,
	input  wire logic [BYTE_W-1:0] rsp_byte_lo,
	output logic                   cmd_valid,
	output logic      [BYTE_W-1:0] cmd_code,
	output logic      [BYTE_W-1:0] cmd_byte_hi,
	output logic      [BYTE_W-1:0] cmd_byte_lo
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_byte_hi = 8'h00;
		cmd_byte_lo = 8'h00;
	end
	task automatic xfer(input logic wr, input logic [7:0] ofs,
		input logic [WIRE_W-1:0] val, output logic [15:0] res);
		logic [WIRE_W-1:0] v;
		v = val;
		if (wr && ofs == OFS_FALL && v[VAL_W-1:0] == '0)
			v = 14'h0001;
		@(negedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= wr ? (ofs | CMD_WRITE_BIT) : ofs;
		cmd_byte_hi <= {1'b0, v[13:7]};
		cmd_byte_lo <= {1'b0, v[6:0]};
		@(negedge clk);
		// Taken one edge ago; the answer is gone after the next edge
		res = {rsp_valid, rsp_error, rsp_byte_hi[6:0], rsp_byte_lo[6:0]};
		cmd_valid <= 1'b0;
		cmd_code <= ~cmd_code;
		cmd_byte_hi <= ~cmd_byte_hi;
		cmd_byte_lo <= ~cmd_byte_lo;
	endtask
endmodule
`default_nettype wire

// [mlsg_regs_bench.sv]
// Purpose: Self-checking bench for the guard register bank
// Assumes: Inputs change on the falling edge
// Notes:   Internal overvolt max lowered to tell it from the default
`timescale 1ns/1ns
`default_nettype none
module mlsg_regs_bench
	import mlsg_pkg::*;
;
	localparam logic [VAL_W-1:0] OV_MAX = 12'h990;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid, rsp_valid, rsp_error, fall_ramp_en;
	logic output_shutdown, low_supply_status, high_supply_status;
	logic [BYTE_W-1:0] cmd_code, cmd_byte_hi, cmd_byte_lo;
	logic [BYTE_W-1:0] rsp_byte_hi, rsp_byte_lo;
	logic [VAL_W-1:0] regen_pot, ramp_pot, supply_level, heatsink_raw;
	logic [VAL_W-1:0] regen_cap, rise_ramp, fall_ramp, e;
	logic [HALF_W-1:0] board_raw;
	logic [NSLOT-1:0] lock_mask, nv_saved_mask;
	logic [NSLOT-1:0][VAL_W-1:0] nv_value;
	logic [15:0] r;
	int failures = 0;
	int n_checks = 0;
	always #5 clk = ~clk;
	mlsg_host_model host (.clk, .rsp_valid, .rsp_error, .rsp_byte_hi,
		.rsp_byte_lo, .cmd_valid, .cmd_code, .cmd_byte_hi, .cmd_byte_lo);
	mlsg_regs #(.OV_INTERNAL_MAX(OV_MAX)) dut (.clk, .sys_rst, .cmd_valid,
		.cmd_code, .cmd_byte_hi, .cmd_byte_lo, .regen_pot, .ramp_pot,
		.lock_mask, .nv_saved_mask, .nv_value, .supply_level,
		.heatsink_raw, .board_raw, .rsp_valid, .rsp_error, .rsp_byte_hi,
		.rsp_byte_lo, .regen_cap, .rise_ramp, .fall_ramp, .fall_ramp_en,
		.output_shutdown, .low_supply_status, .high_supply_status);
	task automatic wrap_up();
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic do_reset();
		sys_rst = 1'b1;
		tick(16);
		sys_rst = 1'b0;
		tick(3);
	endtask
	task automatic t_defaults();
		for (logic [7:0] a = 8'h03; a <= 8'h09; a++) begin
			host.xfer(1'b0, a, 14'h0000, r);
			chk(r, 16'h8000);
		end
		chk({13'h0000, fall_ramp_en, output_shutdown, low_supply_status},
			16'h0000);
		host.xfer(1'b0, OFS_HEATSINK, 14'h0000, r);
		chk(r, 16'h800a);
	endtask
	task automatic t_write_read();
		for (logic [7:0] a = 8'h03; a <= 8'h09; a++) begin
			e = (a == OFS_OV_SHUT) ? OV_MAX : 12'habc;
			host.xfer(1'b1, a, 14'h3abc, r);
			chk(r, {4'h8, e});
			host.xfer(1'b0, a, 14'h0000, r);
			chk(r, {4'h8, e});
		end
		chk({3'h0, fall_ramp_en, fall_ramp}, {4'h1, 12'habc});
	endtask
	task automatic t_pot();
		regen_pot = 12'h321;
		ramp_pot = 12'h654;
		tick(3);
		chk({regen_cap, 4'h0}, {12'h321, 4'h0});
		chk({4'h0, rise_ramp}, 16'h0654);
		host.xfer(1'b1, OFS_REGEN, 14'h0155, r);
		tick(3);
		chk({4'h0, regen_cap}, 16'h0155);
		lock_mask[0] = 1'b1;
		regen_pot = 12'h222;
		tick(3);
		chk({4'h0, regen_cap}, 16'h0155);
	endtask
	// Status bits are registered; two edges leave margin for the update
	task automatic t_supply();
		supply_level = 12'h100;
		host.xfer(1'b1, OFS_UV_SHUT, 14'h0400, r);
		chk({15'h0000, low_supply_status}, 16'h0000);
		lock_mask[3] = 1'b1;
		tick(2);
		chk({14'h0000, output_shutdown, low_supply_status},
			16'h0003);
		host.xfer(1'b1, OFS_UV_RECOVER, 14'h0600, r);
		lock_mask[4] = 1'b1;
		supply_level = 12'h500;
		tick(2);
		chk({15'h0000, low_supply_status}, 16'h0001);
		supply_level = 12'h700;
		tick(2);
		chk({14'h0000, output_shutdown, low_supply_status},
			16'h0000);
		host.xfer(1'b1, OFS_OV_SHUT, 14'h0900, r);
		lock_mask[6] = 1'b1;
		supply_level = 12'h950;
		tick(2);
		chk({14'h0000, output_shutdown, high_supply_status},
			16'h0003);
		host.xfer(1'b1, OFS_OV_RECOVER, 14'h0800, r);
		lock_mask[5] = 1'b1;
		supply_level = 12'h850;
		tick(2);
		chk({15'h0000, high_supply_status}, 16'h0001);
		supply_level = 12'h700;
		tick(2);
		chk({14'h0000, output_shutdown, high_supply_status},
			16'h0000);
	endtask
	task automatic t_temps();
		board_raw = 7'h55;
		heatsink_raw = 12'h064;
		host.xfer(1'b0, OFS_BOARD, 14'h0000, r);
		chk(r, 16'h8055);
		host.xfer(1'b0, OFS_HEATSINK, 14'h0000, r);
		chk(r, 16'h8050);
		for (logic [7:0] a = 8'h0a; a <= 8'h0b; a++) begin
			host.xfer(1'b1, a, 14'h0011, r);
			chk(r, 16'hc000);
		end
		// A code past the last register is refused as well
		host.xfer(1'b0, 8'h0c, 14'h0000, r);
		chk(r, 16'hc000);
	endtask
	task automatic t_restore();
		nv_value[2] = 12'h3c3;
		nv_saved_mask = 7'h04;
		do_reset();
		host.xfer(1'b0, OFS_FALL, 14'h0000, r);
		chk(r, 16'h83c3);
		host.xfer(1'b0, OFS_UV_SHUT, 14'h0000, r);
		chk(r, 16'h8000);
		chk({15'h0000, fall_ramp_en}, 16'h0001);
	endtask
	initial begin
		regen_pot = 12'h000;
		ramp_pot = 12'h000;
		supply_level = 12'h800;
		heatsink_raw = 12'h005;
		board_raw = 7'h00;
		lock_mask = 7'h00;
		nv_saved_mask = 7'h00;
		nv_value = '0;
		do_reset();
		t_defaults();
		t_write_read();
		t_pot();
		t_supply();
		t_temps();
		t_restore();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up();
	end
endmodule
`default_nettype wire
